/* File: logic/tach_gate_interval_counters.sv */
// top: period counter, two interval counters, config registers and slot muxing
//
// Local design decisions: the address-and-strobe port and the address map.
`timescale 1ns/10ps
module tach_gate_interval_counters (
  input  wire logic                              ref_clk_in,
  input  wire logic                              rst_in,
  input  wire logic                              tach_in,
  input  wire logic                              gate_in,
  input  wire tach_gate_pkg::chan_word_t         ain_word_in,
  input  wire logic                              sample_in,
  input  wire logic [tach_gate_pkg::ADDR_W-1:0]  addr_in,
  input  wire logic [31:0]                       wdata_in,
  input  wire logic                              wr_in,
  input  wire logic                              rd_in,
  output tach_gate_pkg::chan_word_t              chan_word_out,
  output logic [31:0]                            rdata_out
);
  import tach_gate_pkg::*;

  // pin synchronisers; stage 1 feeds only stage 2
  logic tach_s1_reg, tach_s2_reg, tach_d_reg;
  logic gate_s1_reg, gate_s2_reg, gate_d_reg;
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      tach_s1_reg <= 1'b0;
      tach_s2_reg <= 1'b0;
      tach_d_reg  <= 1'b0;
      gate_s1_reg <= 1'b0;
      gate_s2_reg <= 1'b0;
      gate_d_reg  <= 1'b0;
    end else begin
      tach_s1_reg <= tach_in;
      tach_s2_reg <= tach_s1_reg;
      tach_d_reg  <= tach_s2_reg;
      gate_s1_reg <= gate_in;
      gate_s2_reg <= gate_s1_reg;
      gate_d_reg  <= gate_s2_reg;
    end
  end

  logic tach_rise, tach_fall, gate_rise, gate_fall;
  assign tach_rise = tach_s2_reg & ~tach_d_reg;
  assign tach_fall = ~tach_s2_reg & tach_d_reg;
  assign gate_rise = gate_s2_reg & ~gate_d_reg;
  assign gate_fall = ~gate_s2_reg & gate_d_reg;

  // configuration registers; defaults: rising edge, zeros, stale flag used
  period_cfg_t   pcfg_reg, pcfg_next;
  interval_cfg_t tcfg_reg, tcfg_next;
  interval_cfg_t gcfg_reg, gcfg_next;
  logic [31:0]   rdata_reg, rdata_next;

  // fields sit at the package positions so software writes and readback agree
  function automatic interval_cfg_t cfg_from_word(input logic [31:0] w);
    interval_cfg_t c;
    c.start_sel = src_sel_t'(w[IC_START_LSB +: 2]);
    c.stop_sel  = src_sel_t'(w[IC_STOP_LSB +: 2]);
    c.keep_last = w[IC_KEEP_BIT];
    return c;
  endfunction

  function automatic logic [31:0] cfg_to_word(input interval_cfg_t c);
    logic [31:0] w;
    w                   = 32'h0000_0000;
    w[IC_START_LSB +: 2] = c.start_sel;
    w[IC_STOP_LSB +: 2]  = c.stop_sel;
    w[IC_KEEP_BIT]       = c.keep_last;
    return w;
  endfunction

  // slot strobes: a slot occurrence is a valid word carrying that channel
  logic rd_period, rd_tach, rd_gate;
  assign rd_period = ain_word_in.valid && (ain_word_in.chan == SLOT_PERIOD);
  assign rd_tach   = ain_word_in.valid && (ain_word_in.chan == SLOT_TACH);
  assign rd_gate   = ain_word_in.valid && (ain_word_in.chan == SLOT_GATE);

  // period counter state
  logic [CNT_W-1:0] per_cnt_reg, per_cnt_next;
  logic [CNT_W-1:0] per_hold_reg, per_hold_next;
  logic             per_arm_reg, per_arm_next;
  logic             per_fresh_reg, per_fresh_next;
  logic             per_edge;
  logic [CNT_W-1:0] per_val;

  logic [CNT_W-1:0] tach_res, gate_res;
  logic             tach_busy, gate_busy;

  always_comb begin
    pcfg_next  = pcfg_reg;
    tcfg_next  = tcfg_reg;
    gcfg_next  = gcfg_reg;
    rdata_next = 32'h0000_0000;
    if (wr_in) begin
      case (addr_in)
        OFS_PERIOD_CFG: begin
          pcfg_next.start_fall = wdata_in[PC_FALL_BIT];
          pcfg_next.keep_prev  = wdata_in[PC_PREV_BIT];
          pcfg_next.stale_off  = wdata_in[PC_STALE_OFF];
        end
        OFS_TACH_CFG:   tcfg_next = cfg_from_word(wdata_in);
        OFS_GATE_CFG:   gcfg_next = cfg_from_word(wdata_in);
        default:        ;
      endcase
    end
    if (rd_in) begin
      case (addr_in)
        OFS_PERIOD_CFG: begin
          rdata_next[PC_FALL_BIT]  = pcfg_reg.start_fall;
          rdata_next[PC_PREV_BIT]  = pcfg_reg.keep_prev;
          rdata_next[PC_STALE_OFF] = pcfg_reg.stale_off;
        end
        OFS_TACH_CFG:   rdata_next = cfg_to_word(tcfg_reg);
        OFS_GATE_CFG:   rdata_next = cfg_to_word(gcfg_reg);
        OFS_STATUS:     rdata_next = {28'h000_0000, gate_busy, tach_busy,
                                      per_fresh_reg, per_arm_reg};
        default:        rdata_next = 32'h0000_0000;
      endcase
    end
  end

  always_comb begin
    per_edge       = pcfg_reg.start_fall ? tach_fall : tach_rise;
    per_cnt_next   = per_cnt_reg;
    per_hold_next  = per_hold_reg;
    per_arm_next   = per_arm_reg;
    per_fresh_next = per_fresh_reg;
    if (rd_period) begin
      per_fresh_next = 1'b0;
    end
    if (per_edge) begin
      // consecutive start edges bound one period; each edge also restarts
      if (per_arm_reg) begin
        per_hold_next  = per_cnt_reg + 32'h0000_0001;
        per_fresh_next = 1'b1;
      end
      per_arm_next = 1'b1;
      per_cnt_next = ZERO_WORD;
    end else if (per_arm_reg) begin
      per_cnt_next = per_cnt_reg + 32'h0000_0001;
    end
  end

  // returned period word: zero or previous value, msb as stale flag
  always_comb begin
    per_val = (per_fresh_reg || pcfg_reg.keep_prev) ? per_hold_reg : ZERO_WORD;
    if (pcfg_reg.stale_off) begin
      per_val[MSB_POS] = 1'b0;
    end else begin
      per_val[MSB_POS] = ~per_fresh_reg;
    end
  end

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      pcfg_reg      <= '0;
      tcfg_reg      <= '0;
      gcfg_reg      <= '0;
      rdata_reg     <= 32'h0000_0000;
      per_cnt_reg   <= ZERO_WORD;
      per_hold_reg  <= ZERO_WORD;
      per_arm_reg   <= 1'b0;
      per_fresh_reg <= 1'b0;
    end else begin
      pcfg_reg      <= pcfg_next;
      tcfg_reg      <= tcfg_next;
      gcfg_reg      <= gcfg_next;
      rdata_reg     <= rdata_next;
      per_cnt_reg   <= per_cnt_next;
      per_hold_reg  <= per_hold_next;
      per_arm_reg   <= per_arm_next;
      per_fresh_reg <= per_fresh_next;
    end
  end

  // pairing of sample with an edge is software's job; unpaired setups
  // simply measure whatever the chosen events give
  interval_counter u_tach_ic (
    .ref_clk_in   (ref_clk_in),
    .rst_in       (rst_in),
    .cfg_in       (tcfg_reg),
    .sample_in    (sample_in),
    .rise_in      (tach_rise),
    .fall_in      (tach_fall),
    .slot_read_in (rd_tach),
    .result_out   (tach_res),
    .busy_out     (tach_busy)
  );

  interval_counter u_gate_ic (
    .ref_clk_in   (ref_clk_in),
    .rst_in       (rst_in),
    .cfg_in       (gcfg_reg),
    .sample_in    (sample_in),
    .rise_in      (gate_rise),
    .fall_in      (gate_fall),
    .slot_read_in (rd_gate),
    .result_out   (gate_res),
    .busy_out     (gate_busy)
  );

  // channel stream: counter slots replace data, analog slots pass through
  chan_word_t word_reg, word_next;
  always_comb begin
    word_next = ain_word_in;
    if (rd_period) begin
      word_next.data = per_val;
    end else if (rd_tach) begin
      word_next.data = tach_res;
    end else if (rd_gate) begin
      word_next.data = gate_res;
    end
  end

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      word_reg <= '0;
    end else begin
      word_reg <= word_next;
    end
  end

  assign chan_word_out = word_reg;
  assign rdata_out     = rdata_reg;

endmodule // tach_gate_interval_counters

/* File: logic/tach_gate_pkg.sv */
// package: constants, selectors and carriers for the tach/gate interval counters
package tach_gate_pkg;

  localparam int          CNT_W          = 32;
  localparam int          CHAN_W         = 4;
  localparam int          MSB_POS        = CNT_W - 1;
  localparam int          ADDR_W         = 4;

  localparam logic [CHAN_W-1:0] SLOT_PERIOD = 4'h4;
  localparam logic [CHAN_W-1:0] SLOT_TACH   = 4'h5;
  localparam logic [CHAN_W-1:0] SLOT_GATE   = 4'h6;

  // register offsets (byte addresses)
  localparam logic [ADDR_W-1:0] OFS_PERIOD_CFG = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_TACH_CFG   = 4'h4;
  localparam logic [ADDR_W-1:0] OFS_GATE_CFG   = 4'h8;
  localparam logic [ADDR_W-1:0] OFS_STATUS     = 4'hc;

  // period config fields
  localparam int          PC_FALL_BIT    = 0;
  localparam int          PC_PREV_BIT    = 1;
  localparam int          PC_STALE_OFF   = 2;
  // interval config fields
  localparam int          IC_START_LSB   = 0;
  localparam int          IC_STOP_LSB    = 2;
  localparam int          IC_KEEP_BIT    = 4;

  localparam logic [CNT_W-1:0] ZERO_WORD = 32'h0000_0000;

  // event source: one-hot codes not needed here, plain select field
  typedef enum logic [1:0] {
    SRC_SAMPLE = 2'h0,
    SRC_RISE   = 2'h1,
    SRC_FALL   = 2'h2
  } src_sel_t;

  typedef struct packed {
    src_sel_t   start_sel;
    src_sel_t   stop_sel;
    logic       keep_last;
  } interval_cfg_t;

  typedef struct packed {
    logic       start_fall;
    logic       keep_prev;
    logic       stale_off;
  } period_cfg_t;

  typedef struct packed {
    logic              valid;
    logic [CHAN_W-1:0] chan;
    logic [CNT_W-1:0]  data;
  } chan_word_t;

endpackage

/* File: logic/interval_counter.sv */
// one start/stop interval counter with latched result and idle-value option
`timescale 1ns/10ps
module interval_counter (
  input  wire logic                               ref_clk_in,
  input  wire logic                               rst_in,
  input  wire tach_gate_pkg::interval_cfg_t       cfg_in,
  input  wire logic                               sample_in,
  input  wire logic                               rise_in,
  input  wire logic                               fall_in,
  input  wire logic                               slot_read_in,
  output logic [tach_gate_pkg::CNT_W-1:0]         result_out,
  output logic                                    busy_out
);
  import tach_gate_pkg::*;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_RUN  = 2'b10
  } ic_state_t;

  ic_state_t        state_reg, state_next;
  logic [CNT_W-1:0] count_reg, count_next;
  logic [CNT_W-1:0] hold_reg, hold_next;
  logic             fresh_reg, fresh_next;
  logic             start_ev, stop_ev;

  function automatic logic pick(input src_sel_t s, input logic smp, input logic r,
                                input logic f);
    case (s)
      SRC_SAMPLE: pick = smp;
      SRC_RISE:   pick = r;
      SRC_FALL:   pick = f;
      default:    pick = 1'b0;
    endcase
  endfunction

  always_comb begin
    start_ev   = pick(cfg_in.start_sel, sample_in, rise_in, fall_in);
    stop_ev    = pick(cfg_in.stop_sel, sample_in, rise_in, fall_in);
    state_next = state_reg;
    count_next = count_reg;
    hold_next  = hold_reg;
    fresh_next = fresh_reg;
    // a read consumes the fresh result; a stop in the same cycle wins
    if (slot_read_in) begin
      fresh_next = 1'b0;
    end
    case (state_reg)
      ST_IDLE: begin
        if (start_ev) begin
          state_next = ST_RUN;
          count_next = ZERO_WORD;
        end
      end
      ST_RUN: begin
        count_next = count_reg + 32'h0000_0001;
        if (stop_ev) begin
          hold_next  = count_reg + 32'h0000_0001;
          fresh_next = 1'b1;
          state_next = ST_IDLE;
        end
      end
      default: state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      state_reg <= ST_IDLE;
      count_reg <= ZERO_WORD;
      hold_reg  <= ZERO_WORD;
      fresh_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      count_reg <= count_next;
      hold_reg  <= hold_next;
      fresh_reg <= fresh_next;
    end
  end

  // zero between measurements unless keep-last is chosen
  assign result_out = (fresh_reg || cfg_in.keep_last) ? hold_reg : ZERO_WORD;
  assign busy_out   = (state_reg == ST_RUN);

endmodule // interval_counter

/* File: sim/tach_gate_source.sv */
// tach and gate pin source model
`timescale 1ns/10ps
module tach_gate_source (
  input  wire logic ref_clk_in,
  output logic      tach_out,
  output logic      gate_out
);
  initial begin
    tach_out = 1'b0;
    gate_out = 1'b0;
  end
  // pins hold their level between steps, like a real sensor line
  task automatic move(input logic g, input int gap);
    repeat (gap) @(posedge ref_clk_in);
    if (g) gate_out <= ~gate_out;
    else tach_out <= ~tach_out;
  endtask
endmodule // tach_gate_source

/* File: sim/tach_gate_interval_counters_checker.sv */
// port-level assertions for the tach/gate interval counters
`timescale 1ns/10ps
module tach_gate_checker (
  input wire logic                             ref_clk_in,
  input wire logic                             rst_in,
  input wire tach_gate_pkg::chan_word_t        ain_word_in,
  input wire logic [tach_gate_pkg::ADDR_W-1:0] addr_in,
  input wire logic [31:0]                      wdata_in,
  input wire logic                             wr_in,
  input wire tach_gate_pkg::chan_word_t        chan_word_out
);
  import tach_gate_pkg::*;
  logic [4:0]       opt_reg, opt_next;
  logic             s4, s5, s6;
  logic [CNT_W-1:0] d;
  assign d  = chan_word_out.data;
  assign s4 = chan_word_out.valid && chan_word_out.chan == SLOT_PERIOD;
  assign s5 = chan_word_out.valid && chan_word_out.chan == SLOT_TACH;
  assign s6 = chan_word_out.valid && chan_word_out.chan == SLOT_GATE;
  // shadow of the option bits so each check knows which reading applies
  always_comb begin
    opt_next = opt_reg;
    if (wr_in && addr_in == OFS_PERIOD_CFG) opt_next[4:2] = wdata_in[2:0];
    if (wr_in && addr_in == OFS_TACH_CFG) opt_next[1] = wdata_in[IC_KEEP_BIT];
    if (wr_in && addr_in == OFS_GATE_CFG) opt_next[0] = wdata_in[IC_KEEP_BIT];
  end
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) opt_reg <= 5'h00;
    else opt_reg <= opt_next;
  end
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);
  property p_vl; ain_word_in.valid |=> chan_word_out.valid; endproperty
  property p_ch; ain_word_in.valid |=> chan_word_out.chan == $past(ain_word_in.chan); endproperty
  property p_ps; ain_word_in.valid && ain_word_in.chan < SLOT_PERIOD
    |=> d == $past(ain_word_in.data); endproperty
  // the output word was built from the options one cycle older than opt_reg
  property p_so; s4 && $past(opt_reg[4]) |-> !d[MSB_POS]; endproperty
  property p_zf; s4 && $past(opt_reg[4:3]) == 2'b00 |-> d != ZERO_WORD; endproperty
  property p_kp; s4 && $past(opt_reg[4:3]) == 2'b11 ##1 s4 |-> d == $past(d); endproperty
  property p_tz; s5 && !$past(opt_reg[1]) ##1 s5 |-> d == ZERO_WORD; endproperty
  property p_gz; s6 && !$past(opt_reg[0]) ##1 s6 |-> d == ZERO_WORD; endproperty
  a_vl: assert property (p_vl) else $error("stream word dropped");
  a_ch: assert property (p_ch) else $error("channel number altered");
  a_ps: assert property (p_ps) else $error("analog word altered");
  a_so: assert property (p_so) else $error("period msb set with flag off");
  a_zf: assert property (p_zf) else $error("period pending reads zero");
  a_kp: assert property (p_kp) else $error("period previous not held");
  a_tz: assert property (p_tz) else $error("tach idle value not zero");
  a_gz: assert property (p_gz) else $error("gate idle value not zero");
  c_per: cover property (s4 && !d[MSB_POS] && d != ZERO_WORD);
  c_tch: cover property (s5 && d != ZERO_WORD);
  c_gat: cover property (s6 && d != ZERO_WORD);
endmodule // tach_gate_checker
bind tach_gate_interval_counters tach_gate_checker tach_gate_checker_i (
  .ref_clk_in(ref_clk_in), .rst_in(rst_in), .ain_word_in(ain_word_in), .addr_in(addr_in),
  .wdata_in(wdata_in), .wr_in(wr_in), .chan_word_out(chan_word_out));

/* File: sim/tach_gate_interval_counters_bench.sv */
// self-checking bench for the tach/gate interval counters
`timescale 1ns/10ps
module tach_gate_interval_counters_bench;
  import tach_gate_pkg::*;
  logic              ref_clk_in, rst_in, sample_in, wr_in, rd_in, rd_d;
  logic              tach_pin, gate_pin;
  chan_word_t        ain_word_in, chan_word_out;
  logic [ADDR_W-1:0] addr_in;
  logic [31:0]       wdata_in, rdata_out, d;
  logic [31:0]       wq[$], rq[$];
  int                errors, tests_run;

  tach_gate_source tach_gate_source_i (.ref_clk_in(ref_clk_in), .tach_out(tach_pin),
    .gate_out(gate_pin));
  tach_gate_interval_counters tach_gate_interval_counters_i (.ref_clk_in(ref_clk_in),
    .rst_in(rst_in), .tach_in(tach_pin), .gate_in(gate_pin), .ain_word_in(ain_word_in),
    .sample_in(sample_in), .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in),
    .rd_in(rd_in), .chan_word_out(chan_word_out), .rdata_out(rdata_out));

  task automatic cmp_word(logic [31:0] e, logic [31:0] s);
    tests_run++;
    if (s !== e) begin
      errors++;
      $display("MISMATCH slot_data exp %h got %h", e, s);
    end
  endtask
  task automatic cmp_reg(logic [31:0] e, logic [31:0] s);
    tests_run++;
    if (s !== e) begin
      errors++;
      $display("MISMATCH reg_data exp %h got %h", e, s);
    end
  endtask
  task automatic slot(logic [3:0] c, logic [31:0] e);
    ain_word_in <= '{1'b1, c, d};
    wr_in <= 1'b0;
    rd_in <= 1'b0;
    wq.push_back(e);
    @(posedge ref_clk_in);
  endtask
  task automatic wr(logic [3:0] a, logic [31:0] v);
    ain_word_in.valid <= 1'b0;
    rd_in <= 1'b0;
    addr_in <= a;
    wdata_in <= v;
    wr_in <= 1'b1;
    @(posedge ref_clk_in);
  endtask
  task automatic rd(logic [3:0] a, logic [31:0] e);
    ain_word_in.valid <= 1'b0;
    wr_in <= 1'b0;
    addr_in <= a;
    rd_in <= 1'b1;
    rq.push_back(e);
    @(posedge ref_clk_in);
  endtask
  task automatic idle(int n);
    ain_word_in.valid <= 1'b0;
    wr_in <= 1'b0;
    rd_in <= 1'b0;
    repeat (n) @(posedge ref_clk_in);
  endtask
  task automatic pulse();
    sample_in <= 1'b1;
    @(posedge ref_clk_in);
    sample_in <= 1'b0;
  endtask
  task automatic tally_and_finish();
    // results that never arrived count as failures too
    errors += wq.size() + rq.size();
    $display("errors %0d tests_run %0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // results are matched in order, the stream never reorders words
  always @(posedge ref_clk_in) begin
    rd_d <= rd_in;
    if (chan_word_out.valid === 1'b1) begin
      cmp_word((wq.size() > 0) ? wq.pop_front() : 32'hxxxx_xxxx, chan_word_out.data);
    end
    if (rd_d === 1'b1) begin
      cmp_reg((rq.size() > 0) ? rq.pop_front() : 32'hxxxx_xxxx, rdata_out);
    end
  end

  initial begin
    ref_clk_in = 1'b0;
    forever #4 ref_clk_in = ~ref_clk_in;
  end
  initial begin
    #40000;
    errors++;
    tally_and_finish();
  end

  initial begin
    rst_in = 1'b1;
    ain_word_in = '0;
    {sample_in, wr_in, rd_in} = 3'b000;
    addr_in = 4'h0;
    wdata_in = 32'h0000_0000;
    {errors, tests_run} = 0;
    void'($urandom(32'h3f06));
    repeat (8) @(posedge ref_clk_in);
    rst_in <= 1'b0;
    repeat (4) begin
      d = $urandom;
      slot({2'b00, d[1:0]}, d);
    end
    slot(SLOT_PERIOD, 32'h8000_0000);
    slot(SLOT_TACH, 32'h0000_0000);
    slot(SLOT_TACH, 32'h0000_0000);
    slot(SLOT_GATE, 32'h0000_0000);
    slot(SLOT_GATE, 32'h0000_0000);
    idle(2);
    // rising start: only one falling edge, so a wrong edge reads pending
    tach_gate_source_i.move(1'b0, 5);
    tach_gate_source_i.move(1'b0, 7);
    tach_gate_source_i.move(1'b0, 13);
    idle(8);
    slot(SLOT_PERIOD, 32'h0000_0014);
    slot(SLOT_PERIOD, 32'h8000_0000);
    wr(OFS_PERIOD_CFG, 32'h0000_0007);
    rd(OFS_PERIOD_CFG, 32'h0000_0007);
    rd(4'h2, 32'h0000_0000);
    idle(1);
    // falls 20 then 15 apart; rises 17 apart, so a rising start would show
    tach_gate_source_i.move(1'b0, 5);
    tach_gate_source_i.move(1'b0, 9);
    tach_gate_source_i.move(1'b0, 11);
    tach_gate_source_i.move(1'b0, 6);
    tach_gate_source_i.move(1'b0, 9);
    idle(8);
    slot(SLOT_PERIOD, 32'h0000_000f);
    slot(SLOT_PERIOD, 32'h0000_000f);
    wr(OFS_TACH_CFG, 32'h0000_0004);
    idle(1);
    pulse();
    tach_gate_source_i.move(1'b0, 10);
    idle(8);
    slot(SLOT_TACH, 32'h0000_000d);
    slot(SLOT_TACH, 32'h0000_0000);
    wr(OFS_TACH_CFG, 32'h0000_0002);
    idle(1);
    tach_gate_source_i.move(1'b0, 2);
    idle(20);
    pulse();
    idle(4);
    slot(SLOT_TACH, 32'h0000_0012);
    wr(OFS_GATE_CFG, 32'h0000_0019);
    idle(1);
    tach_gate_source_i.move(1'b1, 3);
    tach_gate_source_i.move(1'b1, 9);
    idle(8);
    slot(SLOT_GATE, 32'h0000_0009);
    slot(SLOT_GATE, 32'h0000_0009);
    idle(4);
    tally_and_finish();
  end
endmodule // tach_gate_interval_counters_bench
